// ==== hw/cmp_pkg.sv ====
/*
 * constants shared by the comparator control and status block:
 * register indices, field positions, reset values, threshold scaling.
 * assumes a 32-bit apb slave with byte addresses four times the index.
 */
package cmp_pkg;

    // ==================================================================
    // address map
    localparam int unsigned ADDR_W      = 18;
    localparam logic [15:0] IDX_CONTROL = 16'hf0dc;
    localparam logic [15:0] IDX_RESULT  = 16'hf0de;

    // ==================================================================
    // control register fields
    localparam int unsigned CTL_ON_BIT   = 7;
    localparam int unsigned CTL_IE_BIT   = 6;
    localparam int unsigned CTL_EXT_BIT  = 5;
    localparam int unsigned CTL_HYST_BIT = 4;
    localparam int unsigned CTL_CODE_LSB = 0;
    localparam int unsigned CODE_W       = 4;
    localparam logic [7:0]  CTL_RST      = 8'h00;

    // ==================================================================
    // result register fields
    localparam int unsigned RES_FLAG_BIT = 4;
    localparam int unsigned RES_BIT      = 0;
    localparam logic        FLAG_RST     = 1'b0;
    localparam logic        RESULT_RST   = 1'b0;

    // ==================================================================
    // thresholds in units of vcc/30
    localparam int unsigned THR_W          = 5;
    localparam logic [4:0]  THR_UPPER_BASE = 5'h0b;
    localparam logic [4:0]  THR_HYST_STEP  = 5'h02;
    localparam logic [4:0]  THR_NONE       = 5'h00;

    // ==================================================================
    // synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;

    // byte address of a register index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

endpackage : cmp_pkg

// ==== hw/cmp_sync.sv ====
/*
 * two-flop synchroniser for a bundle of asynchronous level inputs.
 * assumes each bit is an independent level; no bus coherence is kept.
 */
`timescale 1ns/1ps
module cmp_sync #(
    parameter int unsigned WIDTH = 3
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    initial begin
        if (WIDTH < 1 || cmp_pkg::SYNC_STAGES != 2) begin
            $error("cmp_sync: unsupported width or depth");
        end
    end

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule : cmp_sync

// ==== hw/cmp_ctrl.sv ====
/*
 * comparator control and status block: apb register slave, threshold
 * selection for the analog front end, hysteresis result tracking,
 * sticky change flag with read-then-write-zero clear.
 * assumes the analog front end returns three raw compare levels
 * (input above upper threshold, above lower threshold, above external
 * reference) asynchronous to clk_i, and an apb master on clk_i.
 */
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module cmp_ctrl (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    // apb slave
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [cmp_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                pwdata_i,
    input  wire logic [3:0]                 pstrb_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // analog front end, raw levels
    input  wire logic                       cmp_hi_raw_i,
    input  wire logic                       cmp_lo_raw_i,
    input  wire logic                       cmp_ext_raw_i,
    // analog front end control
    output logic                            cmp_on_o,
    output logic                            ext_ref_sel_o,
    output logic      [cmp_pkg::THR_W-1:0]  thr_upper_o,
    output logic      [cmp_pkg::THR_W-1:0]  thr_lower_o,
    // interrupt request
    output logic                            irq_req_o
);

    // ==================================================================
    // declarations
    logic [7:0]                  ctrl_ff;
    logic                        flag_ff;
    logic                        armed_ff;
    logic                        result_ff;
    logic [31:0]                 prdata_ff;
    logic [cmp_pkg::THR_W-1:0]   thr_upper_ff;
    logic [cmp_pkg::THR_W-1:0]   thr_lower_ff;
    logic                        irq_req_ff;
    logic [2:0]                  sync_w;
    logic                        hi_s;
    logic                        lo_s;
    logic                        ext_s;
    logic                        comparator_on;
    logic                        compare_irq_enable;
    logic                        ref_source_select;
    logic                        hysteresis_select;
    logic [cmp_pkg::CODE_W-1:0]  ref_level_code;
    logic                        hit_ctrl;
    logic                        hit_result;
    logic                        setup_rd;
    logic                        access;
    logic                        wr_ctrl;
    logic                        wr_result;
    logic                        rd_result;
    logic                        nxt_result;
    logic                        cmp_event;
    logic                        flag_clr;
    logic                        nxt_flag;
    logic [cmp_pkg::THR_W-1:0]   nxt_thr_upper;
    logic [cmp_pkg::THR_W-1:0]   nxt_thr_lower;

    // ==================================================================
    // control fields
    assign comparator_on      = ctrl_ff[cmp_pkg::CTL_ON_BIT];
    assign compare_irq_enable = ctrl_ff[cmp_pkg::CTL_IE_BIT];
    assign ref_source_select  = ctrl_ff[cmp_pkg::CTL_EXT_BIT];
    assign hysteresis_select  = ctrl_ff[cmp_pkg::CTL_HYST_BIT];
    assign ref_level_code     = ctrl_ff[cmp_pkg::CTL_CODE_LSB +: cmp_pkg::CODE_W];

    // ==================================================================
    // apb decode
    assign hit_ctrl   = (paddr_i == cmp_pkg::byte_addr(cmp_pkg::IDX_CONTROL));
    assign hit_result = (paddr_i == cmp_pkg::byte_addr(cmp_pkg::IDX_RESULT));
    assign setup_rd   = psel_i && !penable_i && !pwrite_i;
    assign access     = psel_i && penable_i;
    assign wr_ctrl    = access && pwrite_i && hit_ctrl && pstrb_i[0];
    assign wr_result  = access && pwrite_i && hit_result && pstrb_i[0];
    assign rd_result  = access && !pwrite_i && hit_result;

    // zero wait states; unmapped addresses answer with an error
    assign pready_o  = access;
    assign pslverr_o = access && !hit_ctrl && !hit_result;
    assign prdata_o  = prdata_ff;

    // read data is captured in the setup cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_ff <= 32'h0000_0000;
            if (hit_ctrl) begin
                prdata_ff[7:0] <= ctrl_ff;
            end else if (hit_result) begin
                prdata_ff[cmp_pkg::RES_FLAG_BIT] <= flag_ff;
                prdata_ff[cmp_pkg::RES_BIT]      <= result_ff;
            end
        end
    end

    // ==================================================================
    // control register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_ff <= cmp_pkg::CTL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= pwdata_i[7:0];
        end
    end

    // ==================================================================
    // raw compare synchronisation
    cmp_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .async_i ({cmp_ext_raw_i, cmp_lo_raw_i, cmp_hi_raw_i}),
        .sync_o  (sync_w)
    );

    assign hi_s  = sync_w[0];
    assign lo_s  = sync_w[1];
    assign ext_s = sync_w[2];

    // ==================================================================
    // result tracking
    always_comb begin
        nxt_result = result_ff;
        if (!comparator_on) begin
            nxt_result = cmp_pkg::RESULT_RST;
        end else if (ref_source_select) begin
            // prohibited hysteresis combination behaves as none
            nxt_result = ext_s;
        end else if (!hysteresis_select) begin
            nxt_result = hi_s;
        end else if (!result_ff && hi_s) begin
            nxt_result = 1'b1;
        end else if (result_ff && !lo_s) begin
            nxt_result = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            result_ff <= cmp_pkg::RESULT_RST;
        end else begin
            result_ff <= nxt_result;
        end
    end

    // a halted comparator raises no event
    assign cmp_event = comparator_on && (nxt_result != result_ff);

    // ==================================================================
    // sticky compare event flag
    assign flag_clr = wr_result && !pwdata_i[cmp_pkg::RES_FLAG_BIT] && armed_ff;

    always_comb begin
        nxt_flag = flag_ff;
        if (flag_clr) begin
            nxt_flag = 1'b0;
        end
        if (cmp_event) begin
            nxt_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flag_ff <= cmp_pkg::FLAG_RST;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // remembers that software saw the flag at one
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            armed_ff <= 1'b0;
        end else if (flag_clr) begin
            armed_ff <= 1'b0;
        end else if (rd_result && prdata_ff[cmp_pkg::RES_FLAG_BIT]) begin
            armed_ff <= 1'b1;
        end
    end

    // ==================================================================
    // threshold selection for the front end
    always_comb begin
        nxt_thr_upper = cmp_pkg::THR_NONE;
        nxt_thr_lower = cmp_pkg::THR_NONE;
        if (!ref_source_select) begin
            nxt_thr_upper = cmp_pkg::THR_UPPER_BASE
                          + {{(cmp_pkg::THR_W - cmp_pkg::CODE_W){1'b0}}, ref_level_code};
            nxt_thr_lower = nxt_thr_upper;
            if (hysteresis_select) begin
                nxt_thr_lower = nxt_thr_upper - cmp_pkg::THR_HYST_STEP;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            thr_upper_ff <= cmp_pkg::THR_NONE;
            thr_lower_ff <= cmp_pkg::THR_NONE;
        end else begin
            thr_upper_ff <= nxt_thr_upper;
            thr_lower_ff <= nxt_thr_lower;
        end
    end

    assign thr_upper_o   = thr_upper_ff;
    assign thr_lower_o   = thr_lower_ff;
    assign cmp_on_o      = comparator_on;
    assign ext_ref_sel_o = ref_source_select;

    // ==================================================================
    // interrupt request
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_req_ff <= 1'b0;
        end else begin
            irq_req_ff <= nxt_flag && (wr_ctrl ? pwdata_i[cmp_pkg::CTL_IE_BIT]
                                               : compare_irq_enable);
        end
    end

    assign irq_req_o = irq_req_ff;

    // ==================================================================
    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence hyst_between_s;
        comparator_on && !ref_source_select && hysteresis_select && !hi_s && lo_s;
    endsequence

    sequence clear_write_s;
        wr_result && !pwdata_i[cmp_pkg::RES_FLAG_BIT] && armed_ff && !cmp_event;
    endsequence

    hyst_hold_a: assert property (
        hyst_between_s |=> $stable(result_ff))
        else $error("result moved inside hysteresis band");

    ext_no_hyst_a: assert property (
        (comparator_on && ref_source_select && hysteresis_select)
            |=> result_ff == $past(ext_s))
        else $error("prohibited combination not treated as plain compare");

    upper_only_a: assert property (
        (comparator_on && !ref_source_select && !hysteresis_select)
            |=> result_ff == $past(hi_s))
        else $error("result does not follow upper threshold compare");

    thr_pair_a: assert property (
        (!ref_source_select && hysteresis_select && ref_level_code == 4'h0 && !wr_ctrl)
            |=> thr_upper_o == 5'h0b && thr_lower_o == 5'h09)
        else $error("code zero threshold pair wrong");

    code_ignored_a: assert property (
        (ref_source_select && !wr_ctrl)
            |=> thr_upper_o == 5'h00 && thr_lower_o == 5'h00)
        else $error("level code acts under external reference");

    ext_compare_a: assert property (
        (comparator_on && ref_source_select)
            |=> result_ff == $past(ext_s) ##1 1'b1)
        else $error("external compare result wrong");

    event_sets_a: assert property (
        cmp_event |=> flag_ff)
        else $error("event did not set flag");

    flag_clear_a: assert property (
        ($fell(flag_ff) && !$past(srst_i)) |-> $past(flag_clr))
        else $error("flag cleared without read then zero write");

    clear_takes_a: assert property (
        clear_write_s |=> !flag_ff && !armed_ff)
        else $error("armed zero write did not clear flag");

    write_one_a: assert property (
        (wr_result && pwdata_i[cmp_pkg::RES_FLAG_BIT] && flag_ff) |=> flag_ff)
        else $error("write of one changed flag");

    read_result_a: assert property (
        (setup_rd && hit_result)
            |=> prdata_o[0] == $past(result_ff) && prdata_o[4] == $past(flag_ff))
        else $error("result register read data wrong");

    halt_a: assert property (
        !comparator_on |=> !result_ff && !$rose(flag_ff))
        else $error("halted comparator still active");

    irq_gate_a: assert property (
        irq_req_o == (flag_ff && compare_irq_enable))
        else $error("interrupt request not gated by enable");

    toggle_event_a: assert property (
        ($changed(result_ff) && $past(comparator_on)) |-> flag_ff)
        else $error("result toggle did not raise event");

    hyst_fall_a: assert property (
        (comparator_on && !ref_source_select && hysteresis_select && result_ff && !lo_s)
            |=> !result_ff)
        else $error("result did not fall at lower threshold");

    sync_depth_a: assert property (
        (!$past(srst_i) && !$past(srst_i, 2))
            |-> sync_w == $past({cmp_ext_raw_i, cmp_lo_raw_i, cmp_hi_raw_i}, 2))
        else $error("raw compare not delayed by two flops");

endmodule : cmp_ctrl

// ==== test/cmp_afe_model.sv ====
/*
 * behavioural analog front end: compares an input level against the
 * thresholds or the external reference, all in vcc/30 units.
 * assumes the testbench drives the input and reference levels.
 */
`timescale 1ns/1ps
module cmp_afe_model (
    // clock
    input  wire logic       clk_i,
    // control from the block
    input  wire logic       cmp_on_i,
    input  wire logic [4:0] thr_upper_i,
    input  wire logic [4:0] thr_lower_i,
    // analog levels
    input  wire logic [5:0] ain_i,
    input  wire logic [5:0] ext_ref_i,
    // raw compare outputs
    output logic            hi_o,
    output logic            lo_o,
    output logic            ext_o
);
    // ==========================================================
    // halted comparator output is meaningless: keep it moving
    logic tog_ff;
    always_ff @(posedge clk_i) begin
        tog_ff <= (tog_ff === 1'b1) ? 1'b0 : 1'b1;
    end
    always_comb begin
        hi_o  = cmp_on_i ? (ain_i > {1'b0, thr_upper_i}) : tog_ff;
        lo_o  = cmp_on_i ? (ain_i > {1'b0, thr_lower_i}) : ~tog_ff;
        ext_o = cmp_on_i ? (ain_i > ext_ref_i) : tog_ff;
    end
endmodule : cmp_afe_model

// ==== test/test_comparator_control_status.sv ====
/*
 * self-checking bench for the comparator control block over apb,
 * with the analog front end model on its far side.
 * assumes zero-wait apb answers and a three edge compare path.
 */
`timescale 1ns/1ps
module test_comparator_control_status;
    logic        clk_i, srst_i, psel, penable, pwrite, hi, lo, ext;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        pready, pslverr, cmp_on, ext_sel, irq, er, h;
    logic [4:0]  thr_up, thr_lo;
    logic [5:0]  ain, ext_ref;
    logic [3:0]  code;
    int          errors, total_checks;
    localparam logic [17:0] CTL = {cmp_pkg::IDX_CONTROL, 2'b00};
    localparam logic [17:0] RES = {cmp_pkg::IDX_RESULT, 2'b00};

    cmp_ctrl dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cmp_hi_raw_i(hi),
        .cmp_lo_raw_i(lo), .cmp_ext_raw_i(ext), .cmp_on_o(cmp_on), .ext_ref_sel_o(ext_sel),
        .thr_upper_o(thr_up), .thr_lower_o(thr_lo), .irq_req_o(irq));
    cmp_afe_model afe (.clk_i(clk_i), .cmp_on_i(cmp_on), .thr_upper_i(thr_up),
        .thr_lower_i(thr_lo), .ain_i(ain), .ext_ref_i(ext_ref), .hi_o(hi), .lo_o(lo),
        .ext_o(ext));

    // ==========================================================
    // clock, watchdog, verdict
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        conclude();
    end
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // ==========================================================
    // compare, bus and wait helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    task automatic settle();
        repeat (5) @(posedge clk_i);
    endtask : settle
    task automatic result(input logic e);
        settle();
        apb(1'b0, RES, 8'h00);
        chk({31'h0, rd[0]}, {31'h0, e}, "result bit");
    endtask : result
    function automatic logic [4:0] lower_exp(input logic [3:0] c, input logic hy);
        return hy ? 5'h09 + {1'b0, c} : 5'h0b + {1'b0, c};
    endfunction : lower_exp

    // ==========================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        ain = 6'h00;
        ext_ref = 6'h0a;
        srst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        void'($urandom(32'h1c4b4da1));
        apb(1'b0, CTL, 8'h00);
        chk(rd, 32'h0, "control reset");
        apb(1'b0, 18'h00010, 8'h00);
        chk({31'h0, er}, 32'h1, "unmapped error");
        for (int c = 0; c < 16; c++) begin
            code = c[3:0];
            h = (c == 0) ? 1'b1 : 1'($urandom % 2);
            apb(1'b1, CTL, {3'b100, h, code});
            @(posedge clk_i);
            chk({27'h0, thr_up}, {27'h0, 5'h0b + {1'b0, code}}, "upper");
            chk({27'h0, thr_lo}, {27'h0, lower_exp(code, h)}, "lower");
        end
        code = 4'($urandom);
        apb(1'b1, CTL, {4'b1010, code});
        @(posedge clk_i);
        chk({31'h0, ext_sel}, 32'h1, "ext select");
        apb(1'b0, CTL, 8'h00);
        chk(rd, {24'h0, 4'b1010, code}, "code readback");
        ain <= 6'h0c;
        result(1'b1);
        ain <= 6'h0a;
        result(1'b0);
        apb(1'b1, CTL, 8'hc3);
        ain <= 6'h0e;
        settle();
        apb(1'b0, RES, 8'h00);
        apb(1'b1, RES, 8'h00);
        chk({31'h0, irq}, 32'h0, "irq idle");
        ain <= 6'h0f;
        repeat (2) @(posedge clk_i);
        #1 chk({31'h0, irq}, 32'h0, "irq early");
        @(posedge clk_i);
        #1 chk({31'h0, irq}, 32'h1, "irq on toggle");
        apb(1'b1, RES, 8'h00);
        apb(1'b0, RES, 8'h00);
        chk(rd, 32'h11, "unarmed clear ignored");
        apb(1'b1, RES, 8'h10);
        apb(1'b0, RES, 8'h00);
        chk(rd, 32'h11, "write one ignored");
        pstrb <= 4'h0;
        apb(1'b1, RES, 8'h00);
        pstrb <= 4'hf;
        apb(1'b0, RES, 8'h00);
        chk(rd, 32'h11, "masked clear ignored");
        apb(1'b1, RES, 8'h00);
        apb(1'b0, RES, 8'h00);
        chk(rd, 32'h01, "flag cleared");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        apb(1'b1, CTL, 8'h92);
        ain <= 6'h0e;
        result(1'b1);
        ain <= 6'h0c;
        result(1'b1);
        ain <= 6'h0b;
        result(1'b0);
        ain <= 6'h0d;
        result(1'b0);
        apb(1'b1, CTL, 8'h83);
        settle();
        apb(1'b0, RES, 8'h00);
        chk({31'h0, rd[4]}, 32'h1, "flag set");
        chk({31'h0, irq}, 32'h0, "irq masked");
        ain <= 6'h3f;
        apb(1'b1, CTL, 8'h00);
        chk({31'h0, cmp_on}, 32'h0, "halted");
        result(1'b0);
        conclude();
    end
endmodule : test_comparator_control_status
